// *** verilog/oled_host_defines.svh ***
// Purpose : Shared constants for the display host interface front end.
// Assumes : Included by bare name from every design file that needs it.
// Notes   : Strap codes are listed as proto_sel_1, proto_sel_0.
`ifndef OLED_HOST_DEFINES_SVH
`define OLED_HOST_DEFINES_SVH

// Strap encodings for the four host protocols.
`define PSEL_SPI4 2'b00
`define PSEL_SPI3 2'b01
`define PSEL_P80  2'b10
`define PSEL_P68  2'b11

// Data bus bit positions reused in the serial modes.
`define SERIAL_DATA_IN_BIT  1
`define SCLK_BIT  0

// Bits per serial frame, with and without a leading data/command bit.
`define SPI3_BITS 4'd9
`define SPI4_BITS 4'd8

// Reset value of the driven host data bus.
`define BUS_RESET 8'h00

`endif

// *** verilog/oled_host_pkg.sv ***
// Purpose : Types shared by the host interface front end.
// Assumes : Constants live in oled_host_defines.svh.
// Notes   : All encodings are one-hot.
package oled_host_pkg;

  // Host protocol chosen by the straps.
  typedef enum logic [3:0]
  {
    MODE_SPI4 = 4'b0001,
    MODE_SPI3 = 4'b0010,
    MODE_P68  = 4'b0100,
    MODE_P80  = 4'b1000
  } mode_e;

  // Parallel transfer sequencer states.
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } state_e;

  // All host pins that pass the synchroniser together.
  typedef struct packed
  {
    logic       resetNIn;
    logic [1:0] protoSel;
    logic       csN;
    logic       dcSel;
    logic       enRd;
    logic       rwWr;
    logic [7:0] hostDataBus;
  } host_pins_s;

  // One received byte with its data/command flag.
  typedef struct packed
  {
    logic       isData;
    logic [7:0] data;
  } host_byte_s;

endpackage

// *** verilog/sync_bank.sv ***
// Purpose : Two-flop synchroniser for a bank of asynchronous pins.
// Assumes : Every bit is an independent level from outside the domain.
// Notes   : The first stage is read only by the second stage.
`timescale 1ns/1ns
module sync_bank
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  genvar i;

  // One pair of flip-flops per bit.
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      logic meta_r;
      logic stable_r;
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          meta_r   <= 1'b0;
          stable_r <= 1'b0;
        end
        else
        begin
          meta_r   <= asyncIn[i];
          stable_r <= meta_r;
        end
      end
      assign syncOut[i] = stable_r;
    end
  endgenerate

endmodule

// *** verilog/serial_shifter.sv ***
// Purpose : Serial byte receiver for the 3-wire and 4-wire modes.
// Assumes : Clock edges and data arrive already synchronised.
// Notes   : MSB first; a 3-wire frame leads with its data/command bit.
`timescale 1ns/1ns
module serial_shifter
  import oled_host_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clear,
  input  wire logic       sclkRise,
  input  wire logic       serial_data_in,
  input  wire logic       dcPin,
  input  wire logic       nineBit,
  output logic            done,
  output host_byte_s      rxByte
);
`include "oled_host_defines.svh"

  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic       dcBit_r;
  logic       done_r;
  host_byte_s rxByte_r;
  wire  [3:0] frameBits = nineBit ? `SPI3_BITS : `SPI4_BITS;
  wire  [3:0] cntInc    = cnt_r + 4'd1;
  wire        dcSlot    = nineBit && (cnt_r == 4'd0);
  wire        lastBit   = (cntInc == frameBits);
  wire  [7:0] shiftNxt  = {shift_r[6:0], serial_data_in};

  // Count and shift bits on each serial clock rise while selected.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r    <= 4'd0;
      shift_r  <= 8'h00;
      dcBit_r  <= 1'b0;
      done_r   <= 1'b0;
      rxByte_r <= '0;
    end
    else
    begin
      done_r <= 1'b0;
      if (clear)
        cnt_r <= 4'd0;
      else if (sclkRise)
      begin
        if (dcSlot)
          dcBit_r <= serial_data_in;
        else
          shift_r <= shiftNxt;
        if (lastBit)
        begin
          cnt_r           <= 4'd0;
          done_r          <= 1'b1;
          rxByte_r.data   <= shiftNxt;
          rxByte_r.isData <= nineBit ? dcBit_r : dcPin;
        end
        else
          cnt_r <= cntInc;
      end
    end
  end

  assign done   = done_r;
  assign rxByte = rxByte_r;

endmodule

// *** verilog/oled_host_if.sv ***
// Purpose : Host interface front end: strap-selected SPI or parallel port.
// Assumes : All host pins are asynchronous and pass two flip-flops first.
// Notes   : rdData must stand from the cycle in which readReq is high until the
//           read strobe ends; received bytes appear as one-cycle pulses.
`timescale 1ns/1ns

// Overview of operation
// - The two strap pins pick 3-wire SPI, 4-wire SPI, 68 or 80 parallel.
// - Host traffic is taken only while chip select is low.
// - Data/command high marks display data, low marks a command byte.
// - In 68 mode the enable pin high with chip select low runs a cycle.
// - In 68 mode read/write high reads and low writes.
// - In 80 mode the read strobe low with chip select low starts a read.
// - In 80 mode the write strobe low with chip select low starts a write.
// - Parallel modes use an 8-bit two-way bus, driven only during reads.
// - Serial modes take data on bus bit 1 and clock on bus bit 0.
// - The reset pin restarts strap capture and idles the sequencer and serial receiver.
module oled_host_if
  import oled_host_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       protoSel0,
  input  wire logic       protoSel1,
  input  wire logic       resetNIn,
  input  wire logic       csN,
  input  wire logic       dcSel,
  input  wire logic       enRd,
  input  wire logic       rwWr,
  input  wire logic [7:0] hostDataBusIn,
  input  wire logic [7:0] rdData,
  output logic      [7:0] hostDataBusOut,
  output logic            hostDataBusOe,
  output logic            byteValid,
  output logic      [7:0] byteData,
  output logic            byteIsData,
  output logic            readReq,
  output logic      [3:0] activeMode
);
`include "oled_host_defines.svh"

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------

  host_pins_s pinsRaw;
  host_pins_s pinsS;
  logic [$bits(host_pins_s)-1:0] pinsVec;

  // Gather the pins into one bundle for the synchroniser.
  assign pinsRaw.resetNIn    = resetNIn;
  assign pinsRaw.protoSel    = {protoSel1, protoSel0};
  assign pinsRaw.csN         = csN;
  assign pinsRaw.dcSel       = dcSel;
  assign pinsRaw.enRd        = enRd;
  assign pinsRaw.rwWr        = rwWr;
  assign pinsRaw.hostDataBus = hostDataBusIn;

  sync_bank
  #(
    .WIDTH   ($bits(host_pins_s))
  )
  u_sync
  (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (pinsRaw),
    .syncOut (pinsVec)
  );

  assign pinsS = host_pins_s'(pinsVec);

  // ----------------------------------------------------------------
  // Reset pin and strap capture
  // ----------------------------------------------------------------

  logic  pinRst;
  mode_e mode_r;
  mode_e modeDecode;
  logic  capDone_r;

  // The reset pin synchronously clears the strap capture flag and the sequencer state.
  assign pinRst = !pinsS.resetNIn;

  // Map the strap pair onto a protocol.
  assign modeDecode =
    (pinsS.protoSel == `PSEL_SPI3) ? MODE_SPI3 :
    (pinsS.protoSel == `PSEL_P68)  ? MODE_P68  :
    (pinsS.protoSel == `PSEL_P80)  ? MODE_P80  :
                                     MODE_SPI4;

  // Straps are caught once, at the first cycle out of reset.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_r    <= MODE_SPI4;
      capDone_r <= 1'b0;
    end
    else if (pinRst)
      capDone_r <= 1'b0;
    else if (!capDone_r)
    begin
      mode_r    <= modeDecode;
      capDone_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Mode-dependent strobe decode
  // ----------------------------------------------------------------

  wire is68     = (mode_r == MODE_P68);
  wire is80     = (mode_r == MODE_P80);
  wire isPar    = is68 || is80;
  wire isSer    = !isPar;
  wire csLow    = !pinsS.csN;
  wire live     = capDone_r && !pinRst;
  // The 68 enable is active high; the 80 strobes are active low.
  wire act68    = csLow && pinsS.enRd;
  wire act80    = csLow && (!pinsS.enRd || !pinsS.rwWr);
  wire strobeOn = live && ((is68 && act68) || (is80 && act80));
  // Direction: 68 uses the select level, 80 uses which strobe fell.
  wire isRead   = is68 ? pinsS.rwWr : !pinsS.enRd;

  // ----------------------------------------------------------------
  // Parallel sequencer
  // ----------------------------------------------------------------

  state_e     state_r;
  state_e     state_nxt;
  host_byte_s held_r;
  logic       parDone;
  logic       readStart;

  // Enter on strobe start, leave when the strobe or chip select ends.
  always_comb
  begin
    state_nxt = state_r;
    parDone   = 1'b0;
    readStart = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (strobeOn && isPar)
        begin
          state_nxt = isRead ? ST_READ : ST_WRITE;
          readStart = isRead;
        end
      end
      ST_WRITE:
      begin
        if (!strobeOn)
        begin
          state_nxt = ST_IDLE;
          parDone   = live;
        end
      end
      ST_READ:
      begin
        if (!strobeOn)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Track the last byte seen while a write strobe is active.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      held_r  <= '0;
    end
    else if (pinRst)
      state_r <= ST_IDLE;
    else
    begin
      state_r <= state_nxt;
      if (strobeOn && !isRead)
      begin
        held_r.data   <= pinsS.hostDataBus;
        held_r.isData <= pinsS.dcSel;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial receiver
  // ----------------------------------------------------------------

  logic       sclkD_r;
  logic       serDone;
  host_byte_s serByte;
  wire        sclkS    = pinsS.hostDataBus[`SCLK_BIT];
  wire        sdinS    = pinsS.hostDataBus[`SERIAL_DATA_IN_BIT];
  wire        sclkRise = sclkS && !sclkD_r && live && isSer && csLow;
  wire        serClear = !csLow || !live || isPar;

  // Remember the serial clock level to find its rising edge.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sclkD_r <= 1'b0;
    else
      sclkD_r <= sclkS;
  end

  serial_shifter u_ser
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .clear    (serClear),
    .sclkRise (sclkRise),
    .serial_data_in     (sdinS),
    .dcPin    (pinsS.dcSel),
    .nineBit  (mode_r == MODE_SPI3),
    .done     (serDone),
    .rxByte   (serByte)
  );

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------

  logic       byteValid_r;
  logic [7:0] byteData_r;
  logic       byteIsData_r;
  logic       readReq_r;
  logic [7:0] busOut_r;
  logic       busOe_r;
  wire        serTake = serDone && isSer && live;
  wire        inRead  = (state_r == ST_READ) && strobeOn;

  // Present received bytes and drive the bus during reads.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      byteValid_r  <= 1'b0;
      byteData_r   <= 8'h00;
      byteIsData_r <= 1'b0;
      readReq_r    <= 1'b0;
      busOut_r     <= `BUS_RESET;
      busOe_r      <= 1'b0;
    end
    else
    begin
      byteValid_r <= parDone || serTake;
      readReq_r   <= readStart;
      busOe_r     <= inRead && isPar;
      busOut_r    <= inRead ? rdData : `BUS_RESET;
      if (parDone)
      begin
        byteData_r   <= held_r.data;
        byteIsData_r <= held_r.isData;
      end
      else if (serTake)
      begin
        byteData_r   <= serByte.data;
        byteIsData_r <= serByte.isData;
      end
    end
  end

  assign byteValid      = byteValid_r;
  assign byteData       = byteData_r;
  assign byteIsData     = byteIsData_r;
  assign readReq        = readReq_r;
  assign hostDataBusOut = busOut_r;
  assign hostDataBusOe  = busOe_r;
  assign activeMode     = mode_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  // Strap decode lands in the mode register when capture completes.
  a_mode_strap: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(capDone_r) |-> (mode_r == $past(modeDecode)))
    else $error("Mode does not match straps.");

  // A parallel byte needs chip select low two cycles before.
  a_cs_gates: assert property (
    @(posedge clk) disable iff (!reset_n)
    (byteValid_r && isPar) |-> $past(csLow, 2))
    else $error("Byte accepted without chip select.");

  // Parallel bytes carry the data/command pin level of the strobe's end.
  a_dc_follows: assert property (
    @(posedge clk) disable iff (!reset_n)
    parDone |=> (byteIsData_r == $past(pinsS.dcSel, 2)))
    else $error("Data/command flag lost.");

  // End of a 68 write enable yields a byte next cycle.
  a_e_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    (is68 && live && state_r == ST_WRITE && !act68) |=> byteValid_r)
    else $error("68 write not completed.");

  // A 68 enable with read level raises a read request.
  a_rw_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    (is68 && live && state_r == ST_IDLE && act68 && pinsS.rwWr)
      |=> (readReq_r && !byteValid_r))
    else $error("68 read not started.");

  // An 80 read strobe from idle raises a read request and drives.
  a_rd_strobe: assert property (
    @(posedge clk) disable iff (!reset_n)
    (is80 && live && state_r == ST_IDLE && csLow && !pinsS.enRd)
      |=> readReq_r ##1 (hostDataBusOe || !strobeOn))
    else $error("80 read not started.");

  // Release of the 80 write strobe yields a byte next cycle.
  a_wr_strobe: assert property (
    @(posedge clk) disable iff (!reset_n)
    (is80 && live && state_r == ST_WRITE && !act80) |=> byteValid_r)
    else $error("80 write not completed.");

  // The bus is driven only in a parallel mode.
  a_oe_parallel: assert property (
    @(posedge clk) disable iff (!reset_n)
    hostDataBusOe |-> (isPar && $past(state_r) == ST_READ))
    else $error("Bus driven outside a read.");

  // A serial byte follows a serial clock rise by two cycles.
  a_sclk_byte: assert property (
    @(posedge clk) disable iff (!reset_n)
    (byteValid_r && isSer) |-> $past(sclkRise, 2))
    else $error("Serial byte without clock edge.");

  // Reset pin low silences the outputs from the next cycle.
  a_pin_reset: assert property (
    @(posedge clk) disable iff (!reset_n)
    pinRst |=> (!byteValid_r && !hostDataBusOe && !readReq_r))
    else $error("Activity during pin reset.");

endmodule

// *** sim/host_mcu_model.sv ***
// Purpose : Behavioural host microcontroller for the display host port.
// Assumes : Tasks are called from the bench; pins move at falling edges.
// Notes   : A released bus shows the inverse of the last driven value.
`timescale 1ns/1ns
`include "oled_host_defines.svh"
module host_mcu_model
(
  input  wire logic       clk,
  input  wire logic [7:0] busOut,
  input  wire logic       busOe,
  output logic            protoSel0,
  output logic            protoSel1,
  output logic            resetNIn,
  output logic            csN,
  output logic            dcSel,
  output logic            enRd,
  output logic            rwWr,
  output logic      [7:0] busIn
);
  logic [7:0] hostDrv;
  logic       hostOn;
  logic [1:0] cur;
  logic       rdWin;

  // ------------------------------------------------------------------
  // Pin levels
  // ------------------------------------------------------------------
  // The device wins while enabled, so a floating bus never looks valid.
  assign busIn = busOe ? busOut : (hostOn ? hostDrv : ~hostDrv);

  // Pins start parked with the port held in reset.
  initial
  begin
    cur = `PSEL_SPI4;
    {protoSel1, protoSel0} = `PSEL_SPI4;
    resetNIn = 1'b0;
    csN = 1'b1;
    dcSel = 1'b0;
    hostDrv = 8'h00;
    hostOn = 1'b1;
    rdWin = 1'b0;
    idle_strobes();
  end

  // ------------------------------------------------------------------
  // Host cycles
  // ------------------------------------------------------------------
  // Waits a number of falling edges.
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Serial modes tie both strobes low; parallel modes park them idle.
  task automatic idle_strobes();
    enRd = (cur == `PSEL_P80);
    rwWr = cur[1];
  endtask

  // Sets the straps and pulses the reset pin so they are taken up.
  task automatic set_mode(input logic [1:0] sel);
    @(negedge clk);
    resetNIn = 1'b0;
    {protoSel1, protoSel0} = sel;
    cur = sel;
    hostDrv = 8'h00;
    idle_strobes();
    wait_n(4);
    resetNIn = 1'b1;
    wait_n(8);
  endtask

  // One parallel write; the strobe ends before chip select lifts.
  task automatic par_write(input logic cs, input logic dc,
                           input logic [7:0] d);
    @(negedge clk);
    csN = cs;
    dcSel = dc;
    hostDrv = d;
    rwWr = 1'b0;
    enRd = 1'b1;
    wait_n(4);
    if (cur[0])
      enRd = 1'b0;
    else
      rwWr = 1'b1;
    wait_n(1);
    idle_strobes();
    csN = 1'b1;
    wait_n(3);
  endtask

  // One parallel read; the host lets go of the bus for its length.
  task automatic par_read();
    @(negedge clk);
    rdWin = 1'b1;
    hostOn = 1'b0;
    csN = 1'b0;
    enRd = cur[0];
    rwWr = 1'b1;
    wait_n(6);
    enRd = ~cur[0];
    wait_n(1);
    csN = 1'b1;
    wait_n(5);
    hostOn = 1'b1;
    rdWin = 1'b0;
  endtask

  // Sends nb frame bits MSB first; the clock rests low between frames.
  task automatic spi(input logic cs, input int nb, input logic dc,
                     input logic [7:0] d);
    logic [8:0] f;
    f = {dc, d};
    @(negedge clk);
    csN = cs;
    dcSel = cur[0] ? 1'b0 : dc;
    for (int i = nb - 1; i >= 0; i--)
    begin
      hostDrv = {6'h00, f[i], 1'b0};
      wait_n(4);
      hostDrv[0] = 1'b1;
      wait_n(4);
    end
    hostDrv = 8'h00;
    wait_n(2);
    csN = 1'b1;
    wait_n(4);
  endtask
endmodule

// *** sim/testbench.sv ***
// Purpose : Self-checking bench for the strap-selected host port.
// Assumes : The host model drives every pin; rdData comes from here.
// Notes   : Expected bytes and reads queue up and are matched in order.
`timescale 1ns/1ns
`include "oled_host_defines.svh"
module testbench
  import oled_host_pkg::*;
;
  logic       clk;
  logic       reset_n;
  logic [7:0] rdData;
  logic       protoSel0;
  logic       protoSel1;
  logic       resetNIn;
  logic       csN;
  logic       dcSel;
  logic       enRd;
  logic       rwWr;
  logic [7:0] busIn;
  logic [7:0] hostDataBusOut;
  logic       hostDataBusOe;
  logic       byteValid;
  logic [7:0] byteData;
  logic       byteIsData;
  logic       readReq;
  logic [3:0] activeMode;
  logic [7:0] d;
  logic       dc;
  logic [9:0] note;
  logic [9:0] notes[$];
  int         mismatches;
  int         nChecks;
  logic [1:0] selTab[4] = '{`PSEL_SPI4, `PSEL_SPI3, `PSEL_P68, `PSEL_P80};
  mode_e      modeTab[4] = '{MODE_SPI4, MODE_SPI3, MODE_P68, MODE_P80};

  oled_host_if i_oled_host_if
  (
    .clk(clk), .reset_n(reset_n), .protoSel0(protoSel0),
    .protoSel1(protoSel1), .resetNIn(resetNIn), .csN(csN), .dcSel(dcSel),
    .enRd(enRd), .rwWr(rwWr), .hostDataBusIn(busIn), .rdData(rdData),
    .hostDataBusOut(hostDataBusOut), .hostDataBusOe(hostDataBusOe),
    .byteValid(byteValid), .byteData(byteData), .byteIsData(byteIsData),
    .readReq(readReq), .activeMode(activeMode)
  );

  host_mcu_model i_host_mcu_model
  (
    .clk(clk), .busOut(hostDataBusOut), .busOe(hostDataBusOe),
    .protoSel0(protoSel0), .protoSel1(protoSel1), .resetNIn(resetNIn),
    .csN(csN), .dcSel(dcSel), .enRd(enRd), .rwWr(rwWr), .busIn(busIn)
  );

  // ------------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------------
  // Compares one value and reports a difference at once.
  task automatic chk(input string what, input logic [9:0] seen,
                     input logic [9:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Matches each byte or read result against the oldest note.
  always @(negedge clk)
  begin
    if (reset_n === 1'b1 && byteValid === 1'b1)
    begin
      note = notes.size() ? notes.pop_front() : 10'h2aa;
      chk("byte", {1'b0, byteIsData, byteData}, note);
    end
    if (reset_n === 1'b1 && readReq === 1'b1)
    begin
      note = notes.size() ? notes.pop_front() : 10'h2aa;
      @(negedge clk);
      chk("read", {1'b1, hostDataBusOe, hostDataBusOut}, note);
    end
    else if (reset_n === 1'b1 && !i_host_mcu_model.rdWin)
      chk("idle bus", {2'b00, hostDataBusOut} | 10'(hostDataBusOe), 0);
  end

  // Ends a test once all notes should have been matched.
  task automatic end_test(input int m);
    repeat (12) @(negedge clk);
    chk("pending", 10'(notes.size()), 10'h000);
    $display("test of mode %0d done", m);
  endtask

  // ------------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------------
  always #25 clk = ~clk;

  // Runs every strap mode with good, deselected and held-reset traffic.
  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    rdData = 8'h00;
    mismatches = 0;
    nChecks = 0;
    d = 8'($urandom(61096));
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      i_host_mcu_model.set_mode(selTab[m]);
      chk("mode", 10'(activeMode), 10'(modeTab[m]));
      if (!selTab[m][1])
        i_host_mcu_model.spi(1'b0, 4, 1'b1, 8'h5a);
      for (int k = 0; k < 5; k++)
      begin
        d = 8'($urandom);
        dc = 1'($urandom);
        if (k < 3)
          notes.push_back({1'b0, dc, d});
        if (k == 4)
          i_host_mcu_model.resetNIn = 1'b0;
        if (selTab[m][1])
          i_host_mcu_model.par_write(k == 3, dc, d);
        else
          i_host_mcu_model.spi(k == 3, 8 + selTab[m][0], dc, d);
        if (selTab[m][1] && k < 3)
        begin
          rdData = 8'($urandom);
          notes.push_back({2'b11, rdData});
          i_host_mcu_model.par_read();
        end
      end
      end_test(m);
    end
    report_and_stop();
  end

  // Cuts a hang short well after the tests should have ended.
  initial
  begin
    #1_000_000;
    mismatches++;
    report_and_stop();
  end
endmodule
